// file: core/cms_pkg.sv
// Constants and types shared by the core system register block.
package cms_pkg;

   // ----------------------------------------------------------------
   // Register bus map (byte addresses on the register bus).
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_FLAG     = 12'h000;
   localparam logic [11:0] OFS_MISC     = 12'h008;
   localparam logic [11:0] OFS_IND_SEL  = 12'h00C;
   localparam logic [11:0] OFS_IND_DATA = 12'h010;
   localparam logic [11:0] DMEM_BASE    = 12'h200;
   localparam logic [11:0] DMEM_SPAN    = 12'h200;
   localparam logic [11:0] BITOP_BASE   = 12'h800;
   localparam logic [11:0] BITOP_SPAN   = 12'h800;

   // ----------------------------------------------------------------
   // Program and data memory layout.
   // ----------------------------------------------------------------
   localparam int          DMEM_DEPTH   = 128;
   localparam logic [10:0] PC_RESET_VEC = 11'h000;
   localparam logic [10:0] PC_IRQ_VEC   = 11'h010;
   localparam logic [10:0] PC_SYS_FIRST = 11'h7E0;

   // ----------------------------------------------------------------
   // Status flag and control field layout.
   // ----------------------------------------------------------------
   localparam logic [3:0]  FLAG_RSV_ONES = 4'hF;
   localparam logic [3:0]  FLAG_RESET    = 4'h0;
   localparam int          FLG_Z         = 0;
   localparam int          FLG_C         = 1;
   localparam int          FLG_AC        = 2;
   localparam int          FLG_OV        = 3;
   localparam logic [3:0]  MASK_ARITH    = 4'hF;
   localparam logic [3:0]  MASK_LOGIC    = 4'h1;
   localparam logic [3:0]  MASK_SHIFT    = 4'h2;
   localparam int          MISC_BIAS     = 4;
   localparam int          MISC_LVR_DIS  = 2;
   localparam int          MISC_WDT_LSB  = 0;
   localparam logic [1:0]  WDT_SEL_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Watchdog timebase in low-speed oscillator periods.
   // ----------------------------------------------------------------
   localparam int          WDT_BASE_DEF  = 8192;
   localparam int          WDT_CNT_W     = 18;

   typedef enum logic [1:0] {
      ALU_ADD   = 2'h0,
      ALU_SUB   = 2'h1,
      ALU_SHIFT = 2'h2,
      ALU_LOGIC = 2'h3
   } cms_alu_op_t;

endpackage : cms_pkg

// file: core/cms_flag_calc.sv
// Arithmetic unit that produces a result and its status flag updates.
`timescale 1ns/1ps
module cms_flag_calc
   import cms_pkg::*;
(
   input  wire cms_alu_op_t op_in,     // Operation selector.
   input  wire logic [7:0]  a_in,      // First operand.
   input  wire logic [7:0]  b_in,      // Second operand.
   input  wire logic        carry_in,  // Current carry flag.
   output logic [7:0]       res_out,   // Operation result.
   output logic [3:0]       flag_out,  // New flag values.
   output logic [3:0]       mask_out   // Flags that this operation sets.
);

   logic [8:0] sum;
   logic [4:0] lo;

   // Compute the result and zero flag for each operation, plus carries, borrows and overflow for add and subtract.
   always_comb begin
      sum      = 9'h000;
      lo       = 5'h00;
      res_out  = 8'h00;
      flag_out = 4'h0;
      mask_out = 4'h0;
      case (op_in)
         ALU_ADD: begin
            sum      = {1'b0, a_in} + {1'b0, b_in};
            lo       = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
            res_out  = sum[7:0];
            flag_out[FLG_C]  = sum[8];
            flag_out[FLG_AC] = lo[4];
            flag_out[FLG_OV] = (a_in[7] == b_in[7])
                               && (sum[7] != a_in[7]);
            mask_out = MASK_ARITH;
         end
         ALU_SUB: begin
            sum      = {1'b0, a_in} - {1'b0, b_in};
            lo       = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]};
            res_out  = sum[7:0];
            flag_out[FLG_C]  = sum[8];
            flag_out[FLG_AC] = lo[4];
            flag_out[FLG_OV] = (a_in[7] != b_in[7])
                               && (sum[7] != a_in[7]);
            mask_out = MASK_ARITH;
         end
         ALU_SHIFT: begin
            res_out  = {a_in[6:0], carry_in};
            flag_out[FLG_C] = a_in[7];
            mask_out = MASK_SHIFT;
         end
         ALU_LOGIC: begin
            res_out  = a_in & b_in;
            mask_out = MASK_LOGIC;
         end
         default: begin
            mask_out = 4'h0;
         end
      endcase
      flag_out[FLG_Z] = (res_out == 8'h00);
   end

endmodule : cms_flag_calc

// file: core/cms_sys_regs.sv
// Core system registers, data memory and program address sequencer.
`timescale 1ns/1ps
module cms_sys_regs
   import cms_pkg::*;
#(
   parameter int WDT_BASE_TICKS = WDT_BASE_DEF
) (
   input  wire logic        clk_sys_in,       // System clock, 100 MHz.
   input  wire logic        rst_in,           // Synchronous reset.
   input  wire logic [11:0] paddr_in,         // Register bus address.
   input  wire logic        psel_in,          // Register bus select.
   input  wire logic        penable_in,       // Register bus enable.
   input  wire logic        pwrite_in,        // Register bus write.
   input  wire logic [31:0] pwdata_in,        // Register bus write data.
   input  wire logic [3:0]  pstrb_in,         // Register bus strobes.
   output logic [31:0]      prdata_out,       // Register bus read data.
   output logic             pready_out,       // Register bus ready.
   output logic             pslverr_out,      // Register bus error.
   input  wire logic        alu_valid_in,     // Operation strobe.
   input  wire cms_alu_op_t alu_op_in,        // Operation selector.
   input  wire logic [7:0]  alu_a_in,         // First operand.
   input  wire logic [7:0]  alu_b_in,         // Second operand.
   output logic [7:0]       alu_result_out,   // Last operation result.
   input  wire logic        fetch_step_in,    // Advance fetch address.
   input  wire logic        jump_in,          // Load jump target.
   input  wire logic [10:0] jump_addr_in,     // Jump target.
   input  wire logic        irq_take_in,      // Interrupt taken.
   output logic [10:0]      pc_out,           // Fetch address.
   output logic             pc_sys_area_out,  // Fetch in system area.
   output logic             bias_en_out,      // Bias generator enable.
   output logic             lvr_disable_out,  // Low-voltage reset off.
   output logic [1:0]       wdt_period_out,   // Watchdog period select.
   input  wire logic        lsosc_in,         // Low-speed oscillator.
   input  wire logic        wdt_clear_in,     // Watchdog restart.
   output logic             wdt_timeout_out   // Watchdog timeout pulse.
);

   // ----------------------------------------------------------------
   // Helper functions.
   // ----------------------------------------------------------------

   // True when an aligned address falls inside a window.
   function automatic logic in_win(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input logic [11:0] span);
      logic [11:0] rel;
      rel = a - base;
      return (a[1:0] == 2'b00) && (a >= base) && (rel < span);
   endfunction : in_win

   // Last tick count of the selected watchdog period.
   function automatic logic [WDT_CNT_W-1:0] wdt_limit(
      input logic [1:0] sel);
      int t;
      case (sel)
         2'h0:    t = WDT_BASE_TICKS;
         2'h1:    t = WDT_BASE_TICKS * 2;
         2'h2:    t = WDT_BASE_TICKS * 8;
         default: t = WDT_BASE_TICKS * 32;
      endcase
      t = t - 1;
      return t[WDT_CNT_W-1:0];
   endfunction : wdt_limit

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   logic [7:0]  dmem_q [DMEM_DEPTH];
   logic [7:0]  dmem_d [DMEM_DEPTH];
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [3:0]  flag_q, flag_d;
   logic [7:0]  alu_res_q, alu_res_d;
   logic [10:0] pc_q, pc_d;
   logic        sys_q, sys_d;
   logic        bias_q, bias_d;
   logic        lvr_q, lvr_d;
   logic [1:0]  wsel_q, wsel_d;
   logic [6:0]  isel_q, isel_d;
   logic [2:0]  osc_s_q;
   logic        osc_lvl_q, osc_lvl_d;
   logic [WDT_CNT_W-1:0] wcnt_q, wcnt_d;
   logic        wto_q, wto_d;

   logic        acc, commit;
   logic        hit_flag, hit_misc, hit_isel, hit_idat;
   logic        hit_dmem, hit_bit, mapped;
   logic [6:0]  ind_ptr, bit_byte;
   logic [2:0]  bit_pos;
   logic        osc_tick;
   logic [7:0]  calc_res;
   logic [3:0]  calc_flag, calc_mask;

   cms_flag_calc u_calc (
      .op_in    (alu_op_in),
      .a_in     (alu_a_in),
      .b_in     (alu_b_in),
      .carry_in (flag_q[FLG_C]),
      .res_out  (calc_res),
      .flag_out (calc_flag),
      .mask_out (calc_mask)
   );

   // ----------------------------------------------------------------
   // Address decode; each space has its own window.
   // ----------------------------------------------------------------

   // Decode the bus address and derive pointers for indirect access.
   always_comb begin
      acc      = psel_in & penable_in;
      hit_flag = (paddr_in == OFS_FLAG);
      hit_misc = (paddr_in == OFS_MISC);
      hit_isel = (paddr_in == OFS_IND_SEL);
      hit_idat = (paddr_in == OFS_IND_DATA);
      hit_dmem = in_win(paddr_in, DMEM_BASE, DMEM_SPAN);
      hit_bit  = in_win(paddr_in, BITOP_BASE, BITOP_SPAN);
      mapped   = hit_flag | hit_misc | hit_isel | hit_idat
                 | hit_dmem | hit_bit;
      commit   = acc & pready_q & pwrite_in & pstrb_in[0] & mapped;
      ind_ptr  = dmem_q[isel_q][6:0];
      bit_byte = {1'b0, paddr_in[10:5]};
      bit_pos  = paddr_in[4:2];
   end

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, answer registered.
   // ----------------------------------------------------------------

   // Build read data and error in the first access cycle.
   always_comb begin
      pready_d  = acc & ~pready_q;
      pslverr_d = acc & ~pready_q & ~mapped;
      prdata_d  = 32'h0000_0000;
      if (acc & ~pready_q & ~pwrite_in) begin
         if (hit_flag) begin
            prdata_d[7:0] = {FLAG_RSV_ONES, flag_q};
         end else if (hit_isel) begin
            prdata_d[6:0] = isel_q;
         end else if (hit_idat) begin
            prdata_d[7:0] = dmem_q[ind_ptr];
         end else if (hit_dmem) begin
            prdata_d[7:0] = dmem_q[paddr_in[8:2]];
         end else if (hit_bit) begin
            prdata_d[0] = dmem_q[bit_byte][bit_pos];
         end
      end
   end

   // Register the bus answer.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------------------------------
   // Data memory: byte, bit and indirect access.
   // ----------------------------------------------------------------

   // Apply at most one bus write to the data bytes.
   always_comb begin
      dmem_d = dmem_q;
      if (commit & hit_dmem) begin
         dmem_d[paddr_in[8:2]] = pwdata_in[7:0];
      end else if (commit & hit_idat) begin
         dmem_d[ind_ptr] = pwdata_in[7:0];
      end else if (commit & hit_bit) begin
         dmem_d[bit_byte][bit_pos] = pwdata_in[0];
      end
   end

   // Data bytes are storage only and need no reset.
   always_ff @(posedge clk_sys_in) begin
      dmem_q <= dmem_d;
   end

   // ----------------------------------------------------------------
   // Status flags, control register and fetch address.
   // ----------------------------------------------------------------

   // Hardware flag updates win over a software write in the same cycle.
   always_comb begin
      flag_d    = flag_q;
      alu_res_d = alu_res_q;
      bias_d    = bias_q;
      lvr_d     = lvr_q;
      wsel_d    = wsel_q;
      isel_d    = isel_q;
      if (commit & hit_flag) begin
         flag_d = pwdata_in[3:0];
      end
      if (alu_valid_in) begin
         flag_d    = (flag_d & ~calc_mask) | (calc_flag & calc_mask);
         alu_res_d = calc_res;
      end
      if (commit & hit_misc) begin
         bias_d = pwdata_in[MISC_BIAS];
         lvr_d  = pwdata_in[MISC_LVR_DIS];
         wsel_d = pwdata_in[MISC_WDT_LSB +: 2];
      end
      if (commit & hit_isel) begin
         isel_d = pwdata_in[6:0];
      end
      if (irq_take_in) begin
         pc_d = PC_IRQ_VEC;
      end else if (jump_in) begin
         pc_d = jump_addr_in;
      end else if (fetch_step_in) begin
         pc_d = pc_q + 11'h001;
      end else begin
         pc_d = pc_q;
      end
      sys_d = (pc_d >= PC_SYS_FIRST);
   end

   // Register flags, control fields and fetch address.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         flag_q    <= FLAG_RESET;
         alu_res_q <= 8'h00;
         bias_q    <= 1'b0;
         lvr_q     <= 1'b0;
         wsel_q    <= WDT_SEL_RESET;
         isel_q    <= 7'h00;
         pc_q      <= PC_RESET_VEC;
         sys_q     <= 1'b0;
      end else begin
         flag_q    <= flag_d;
         alu_res_q <= alu_res_d;
         bias_q    <= bias_d;
         lvr_q     <= lvr_d;
         wsel_q    <= wsel_d;
         isel_q    <= isel_d;
         pc_q      <= pc_d;
         sys_q     <= sys_d;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog on the low-speed oscillator.
   // ----------------------------------------------------------------

   // Filter the oscillator level and count its rising edges.
   always_comb begin
      osc_lvl_d = (osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : osc_lvl_q;
      osc_tick  = osc_lvl_d & ~osc_lvl_q;
      wto_d     = 1'b0;
      wcnt_d    = wcnt_q;
      if (wdt_clear_in) begin
         wcnt_d = '0;
      end else if (osc_tick) begin
         if (wcnt_q == wdt_limit(wsel_q)) begin
            wcnt_d = '0;
            wto_d  = 1'b1;
         end else begin
            wcnt_d = wcnt_q + 1'b1;
         end
      end
   end

   // Synchronise the oscillator and register the watchdog.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         osc_s_q   <= 3'h0;
         osc_lvl_q <= 1'b0;
         wcnt_q    <= '0;
         wto_q     <= 1'b0;
      end else begin
         osc_s_q   <= {osc_s_q[1:0], lsosc_in};
         osc_lvl_q <= osc_lvl_d;
         wcnt_q    <= wcnt_d;
         wto_q     <= wto_d;
      end
   end

   // Outputs come straight from flip-flops.
   assign prdata_out      = prdata_q;
   assign pready_out      = pready_q;
   assign pslverr_out     = pslverr_q;
   assign alu_result_out  = alu_res_q;
   assign pc_out          = pc_q;
   assign pc_sys_area_out = sys_q;
   assign bias_en_out     = bias_q;
   assign lvr_disable_out = lvr_q;
   assign wdt_period_out  = wsel_q;
   assign wdt_timeout_out = wto_q;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   property p_reset_vec;
      $fell(rst_in) |-> pc_out == PC_RESET_VEC;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("Fetch did not start at the reset address.");

   property p_irq_vec;
      irq_take_in |=> pc_out == PC_IRQ_VEC;
   endproperty
   a_irq_vec: assert property (p_irq_vec)
      else $error("Interrupt did not vector to its entry.");

   property p_sys_area;
      pc_sys_area_out == (pc_out >= PC_SYS_FIRST);
   endproperty
   a_sys_area: assert property (p_sys_area)
      else $error("System area indication wrong.");

   property p_flag_ones;
      pready_out && $past(acc && !pwrite_in && hit_flag)
         |-> prdata_out[7:4] == FLAG_RSV_ONES;
   endproperty
   a_flag_ones: assert property (p_flag_ones)
      else $error("Flag upper bits did not read as one.");

   property p_ovf;
      alu_valid_in && alu_op_in == ALU_ADD && alu_a_in == 8'h7F
         && alu_b_in == 8'h01 |=> flag_q[FLG_OV] && flag_q[FLG_AC];
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("Signed overflow or nibble carry missed.");

   property p_shift_c;
      alu_valid_in && alu_op_in == ALU_SHIFT
         |=> flag_q[FLG_C] == $past(alu_a_in[7]);
   endproperty
   a_shift_c: assert property (p_shift_c)
      else $error("Shift did not move bit 7 into carry.");

   property p_zero;
      alu_valid_in && alu_op_in != ALU_SHIFT
         |=> flag_q[FLG_Z] == (alu_result_out == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("Zero flag disagrees with result.");

   property p_misc_wr;
      commit && hit_misc |=> bias_en_out == $past(pwdata_in[MISC_BIAS])
         && lvr_disable_out == $past(pwdata_in[MISC_LVR_DIS]);
   endproperty
   a_misc_wr: assert property (p_misc_wr)
      else $error("Control write did not reach outputs.");

   property p_wdt;
      wdt_timeout_out |-> $past(wcnt_q) == wdt_limit(wdt_period_out);
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("Watchdog fired at the wrong count.");

   property p_bitop;
      commit && hit_bit |=> dmem_q[$past(bit_byte)][$past(bit_pos)]
         == $past(pwdata_in[0]);
   endproperty
   a_bitop: assert property (p_bitop)
      else $error("Bit write did not land.");

   c_irq:   cover property (irq_take_in ##1 pc_out == PC_IRQ_VEC);
   c_bit:   cover property (commit && hit_bit);
   c_wdt:   cover property (wdt_timeout_out);
   c_error: cover property (pslverr_out && pready_out);

endmodule : cms_sys_regs

// file: dv/cms_sys_regs_bench.sv
// Self-checking bench for the core system register block.
`timescale 1ns/1ps
module cms_sys_regs_bench;
   import cms_pkg::*;
   // ----------------------------------------------------------------
   // Signals and counters.
   // ----------------------------------------------------------------
   localparam int BASE = 8;
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [11:0] paddr_in = '0;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [31:0] pwdata_in = '0;
   logic [3:0]  pstrb_in = 4'hF;
   logic [31:0] prdata_out;
   logic        pready_out, pslverr_out;
   logic        alu_valid_in = 1'b0;
   cms_alu_op_t alu_op_in = ALU_ADD;
   logic [7:0]  alu_a_in = '0, alu_b_in = '0, alu_result_out;
   logic        fetch_step_in = 1'b0, jump_in = 1'b0, irq_take_in = 1'b0;
   logic [10:0] jump_addr_in = '0, pc_out;
   logic        pc_sys_area_out, bias_en_out, lvr_disable_out;
   logic [1:0]  wdt_period_out;
   logic        lsosc_in = 1'b0, wdt_clear_in = 1'b1, wdt_timeout_out;
   logic [2:0]  div = '0;
   int          fails = 0, n_checks = 0, cycles = 0;

   cms_sys_regs #(.WDT_BASE_TICKS(BASE)) dut (.clk_sys_in, .rst_in,
      .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .pstrb_in,
      .prdata_out, .pready_out, .pslverr_out, .alu_valid_in, .alu_op_in,
      .alu_a_in, .alu_b_in, .alu_result_out, .fetch_step_in, .jump_in,
      .jump_addr_in, .irq_take_in, .pc_out, .pc_sys_area_out, .bias_en_out,
      .lvr_disable_out, .wdt_period_out, .lsosc_in, .wdt_clear_in,
      .wdt_timeout_out);

   // Clock, slow oscillator of eight system cycles, and hang guard.
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      div <= div + 3'h1;
      lsosc_in <= div[2];
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One register bus transfer; holds the request until ready is seen.
   // A slave that never answers is caught by the cycle guard.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask : wr

   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] x, input logic ex = 1'b0);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, x, r);
      chk({nm, " err"}, {31'h0, ex}, {31'h0, e});
   endtask : rdc

   // One cycle of fetch control, then the new fetch address is checked.
   task automatic pc_do(input logic i, j, s, input logic [10:0] ja,
                        input logic [10:0] x, input logic sys);
      @(posedge clk_sys_in);
      irq_take_in <= i;
      jump_in <= j;
      fetch_step_in <= s;
      jump_addr_in <= ja;
      @(posedge clk_sys_in);
      {irq_take_in, jump_in, fetch_step_in} <= 3'h0;
      @(posedge clk_sys_in);
      #1 chk("pc", {21'h0, x}, {21'h0, pc_out});
      chk("sys area", {31'h0, sys}, {31'h0, pc_sys_area_out});
   endtask : pc_do

   // One operation strobe; result and flag readback are compared.
   task automatic alu(input cms_alu_op_t op, input logic [7:0] a, b, r,
                      input logic [7:0] f);
      @(posedge clk_sys_in);
      alu_valid_in <= 1'b1;
      alu_op_in <= op;
      alu_a_in <= a;
      alu_b_in <= b;
      @(posedge clk_sys_in);
      alu_valid_in <= 1'b0;
      #1 chk("result", {24'h0, r}, {24'h0, alu_result_out});
      rdc("flags", OFS_FLAG, {24'h0, f});
   endtask : alu

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("pc reset", 32'h0, {21'h0, pc_out});
      rdc("flag reset", OFS_FLAG, 32'hF0);
      rdc("misc read", OFS_MISC, 32'h0);
      chk("misc outs", 32'h0, {bias_en_out, lvr_disable_out,
          wdt_period_out});
   endtask : t_reset

   task automatic t_fetch();
      pc_do(1, 1, 1, 11'h100, 11'h010, 0);
      pc_do(0, 0, 1, 11'h000, 11'h011, 0);
      pc_do(0, 1, 0, 11'h7DF, 11'h7DF, 0);
      pc_do(0, 0, 1, 11'h000, 11'h7E0, 1);
      pc_do(0, 1, 0, 11'h7FF, 11'h7FF, 1);
      pc_do(0, 0, 1, 11'h000, 11'h000, 0);
   endtask : t_fetch

   task automatic t_alu();
      alu(ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'hFC);
      alu(ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'hF7);
      alu(ALU_SUB, 8'h10, 8'h01, 8'h0F, 8'hF4);
      alu(ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'hF6);
      alu(ALU_SHIFT, 8'h00, 8'h00, 8'h01, 8'hF4);
      alu(ALU_LOGIC, 8'hF0, 8'h0F, 8'h00, 8'hF5);
      wr(OFS_FLAG, 8'h0A);
      rdc("flag write", OFS_FLAG, 32'hFA);
   endtask : t_alu

   task automatic t_misc();
      int sh[4] = '{0, 1, 3, 5};
      int t, n;
      logic prev;
      for (int s = 0; s < 4; s++) begin
         wr(OFS_MISC, {3'b000, 3'b101, s[1:0]});
         #1 chk("misc outs", {28'h0, 1'b1, 1'b1, s[1:0]}, {28'h0,
            bias_en_out, lvr_disable_out, wdt_period_out});
         rdc("misc wo", OFS_MISC, 32'h0);
         wdt_clear_in <= 1'b1;
         repeat (8) @(posedge clk_sys_in);
         wdt_clear_in <= 1'b0;
         t = 0;
         n = 0;
         prev = lsosc_in;
         while (wdt_timeout_out !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            #1 n++;
            if (lsosc_in && !prev) t++;
            prev = lsosc_in;
         end
         // An oscillator edge just before the restart still reaches the
         // counter after the synchroniser delay, so one tick may be early.
         chk("wdt ticks", 32'h1, {31'h0, t + 1 >= (BASE << sh[s]) &&
             t <= (BASE << sh[s])});
      end
      wr(OFS_MISC, 8'h00);
      #1 chk("misc off", 32'h0, {bias_en_out, lvr_disable_out});
   endtask : t_misc

   task automatic t_mem();
      wr(DMEM_BASE + 12'h014, 8'h20);
      wr(DMEM_BASE + 12'h080, 8'hA5);
      wr(DMEM_BASE + 12'h1FC, 8'h7E);
      wr(OFS_IND_SEL, 8'h05);
      rdc("indirect", OFS_IND_DATA, 32'hA5);
      pstrb_in <= 4'hE;
      wr(DMEM_BASE + 12'h080, 8'h00);
      pstrb_in <= 4'hF;
      rdc("strobe off", DMEM_BASE + 12'h080, 32'hA5);
      rdc("top byte", DMEM_BASE + 12'h1FC, 32'h7E);
      rdc("bit0", BITOP_BASE + 12'h400, 32'h1);
      rdc("bit1", BITOP_BASE + 12'h404, 32'h0);
      wr(BITOP_BASE + 12'h40C, 8'h01);
      rdc("bit set", DMEM_BASE + 12'h080, 32'hAD);
      wr(DMEM_BASE, 8'h00);
      rdc("no alias", OFS_FLAG, 32'hFA);
      rdc("unmapped", 12'h004, 32'h0, 1'b1);
   endtask : t_mem

   // ----------------------------------------------------------------
   // Closing report and main sequence.
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reset();
      $display("reset test done");
      t_fetch();
      $display("fetch test done");
      t_alu();
      $display("flag test done");
      t_misc();
      $display("control test done");
      t_mem();
      $display("memory test done");
      complete_run();
   end
endmodule : cms_sys_regs_bench
